// ### pss_defs.vh
// constants for the port shutdown supervisor: offsets, fields, resets, timing
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH

// register offsets
`define PSS_A_PRIO_FLAGS  8'h15
`define PSS_A_GEN_MASK    8'h17
`define PSS_A_PWR_EN_ALT  8'h19
`define PSS_A_SOFT_RST    8'h1a
`define PSS_A_STD_ON      8'h23
`define PSS_A_MAP_SEL     8'h26
`define PSS_A_LVL_LO      8'h27
`define PSS_A_LVL_HI      8'h28
`define PSS_A_WDOG        8'h30
`define PSS_A_ON_TIM_AUX  8'h40

// field positions
`define PSS_B_MULTI_LVL   7
`define PSS_B_WDOG_FLAG   0
`define PSS_F_WDOG_DIS    4:1

// reset values
`define PSS_R_MAP_SEL     8'he4
`define PSS_R_WDOG_DIS    4'hb
`define PSS_R_BYTE        8'h00

// timing in their own units
`define PSS_CLK_NS        8
`define PSS_TICK_NS       1000000
`define PSS_COOL_MS       1000
`define PSS_WDOG_MS       2000
`define PSS_DGL_NS        3000
`define PSS_BIT_NS        25000

`endif

// ### pss_host_model.sv
// host side: shutdown line and serial clock
`timescale 1ns/1ps
`default_nettype none

module pss_host_model (
  // clock
  input  wire logic i_ref_clk,
  // host pins
  output var logic  o_line,
  output var logic  o_scl
);
  logic run;
  initial begin
    o_line = 1'b0;
    o_scl = 1'b1;
    run = 1'b1;
  end
  // serial clock toggles only while the host is active
  always #62.5 if (run) o_scl = ~o_scl;
  // drive the line for a number of cycles
  task automatic hold(input logic v, input int cyc);
    o_line <= v;
    repeat (cyc) @(posedge i_ref_clk);
  endtask
  // start bit then code msb first, 25 us each, then idle gap
  task automatic frame(input logic [2:0] c);
    hold(1'b1, 3125);
    hold(c[2], 3125);
    hold(c[1], 3125);
    hold(c[0], 3125);
    hold(1'b0, 6250);
  endtask
endmodule

`default_nettype wire

// ### pss_port_supervisor.v
// port supervisor: restart, cool-down, turn-on gating, remap, shutdown, watchdog
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.vh"

module pss_port_supervisor #(
  parameter integer NPORT     = 8,
  parameter integer TICK_CYC  = `PSS_TICK_NS / `PSS_CLK_NS,
  parameter integer COOL_TICK = `PSS_COOL_MS,
  parameter integer WDOG_TICK = `PSS_WDOG_MS
) (
  // clock, reset, enable
  input  wire             i_ref_clk,
  input  wire             i_srst,
  input  wire             i_clk_en,
  // register access from the serial interface
  input  wire             i_reg_wr,
  input  wire             i_reg_rd,
  input  wire [7:0]       i_reg_addr,
  input  wire [7:0]       i_reg_wdata,
  output reg  [7:0]       o_reg_rdata,
  // pins
  input  wire             i_fast_shutdown_input,
  input  wire             i_scl,
  // per logical port status from the port engine
  input  wire [NPORT-1:0] i_port_fault,
  input  wire [NPORT-1:0] i_port_disconnect,
  input  wire [NPORT-1:0] i_port_off_cmd,
  input  wire [NPORT-1:0] i_port_off_mode,
  input  wire [NPORT-1:0] i_detect_request,
  input  wire [NPORT-1:0] i_det_valid,
  input  wire [NPORT-1:0] i_class_bad,
  input  wire [NPORT-1:0] i_power_good,
  input  wire [NPORT-1:0] i_extended_power_curve_select,
  // per physical port controls
  output reg  [NPORT-1:0] o_port_power_on,
  output reg  [NPORT-1:0] o_curve_2x,
  output reg  [NPORT-1:0] o_detect_enable,
  // serial interface reset pulse
  output reg              o_serial_if_reset
);

  reg [7:0]       prio_flags_q;
  reg [7:0]       gen_mask_q;
  reg [7:0]       pwr_en_alt_q;
  reg [7:0]       map_sel_q;
  reg [7:0]       lvl_lo_q;
  reg [7:0]       lvl_hi_q;
  reg [7:0]       on_tim_aux_q;
  reg [3:0]       wdog_dis_q;
  reg             watchdog_expired_flag_q;
  reg [NPORT-1:0] power_q;
  reg [NPORT-1:0] cooling_q;
  reg [NPORT-1:0] det_allow_q;
  reg [NPORT-1:0] kill_q;
  reg [1:0]       oss_sync_q;
  reg [1:0]       scl_sync_q;
  reg             scl_last_q;
  reg [19:0]      tick_cnt_q;
  reg             tick_q;
  reg [11:0]      wdog_cnt_q;
  reg             wdog_fire_q;
  reg [NPORT-1:0] phys_power_d;
  reg [NPORT-1:0] phys_curve_d;
  reg [NPORT-1:0] phys_det_d;
  reg [NPORT-1:0] kill_d;
  reg [7:0]       rdata_d;
  integer         l;
  integer         k;

  wire            wr_soft_rst  = i_reg_wr && (i_reg_addr == `PSS_A_SOFT_RST);
  wire            wr_std_on    = i_reg_wr && (i_reg_addr == `PSS_A_STD_ON);
  wire            wr_alt_on    = i_reg_wr && (i_reg_addr == `PSS_A_PWR_EN_ALT);
  wire            multi_mode   = gen_mask_q[`PSS_B_MULTI_LVL];
  wire            wdog_enabled = (wdog_dis_q != `PSS_R_WDOG_DIS);
  wire            scl_edge     = scl_sync_q[1] ^ scl_last_q;
  wire            oss_level;
  wire            code_valid;
  wire [2:0]      code;
  wire [15:0]     lvl_all      = {lvl_hi_q, lvl_lo_q};
  wire [1:0]      m0           = i_reg_wdata[1:0];
  wire [1:0]      m1           = i_reg_wdata[3:2];
  wire [1:0]      m2           = i_reg_wdata[5:4];
  wire [1:0]      m3           = i_reg_wdata[7:6];
  wire            map_unique   = (m0 != m1) && (m0 != m2) && (m0 != m3) &&
                                 (m1 != m2) && (m1 != m3) && (m2 != m3);

  // pins pass two flip-flops before anything reads them
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      oss_sync_q <= 2'h0;
      scl_sync_q <= 2'h0;
      scl_last_q <= 1'b0;
    end else if (i_clk_en) begin
      oss_sync_q <= {oss_sync_q[0], i_fast_shutdown_input};
      scl_sync_q <= {scl_sync_q[0], i_scl};
      scl_last_q <= scl_sync_q[1];
    end
  end

  // deglitch and three-bit code receiver
  pss_shutdown_rx u_rx (
    .i_ref_clk    (i_ref_clk),
    .i_srst       (i_srst),
    .i_clk_en     (i_clk_en),
    .i_line       (oss_sync_q[1]),
    .i_multi_mode (multi_mode),
    .o_level      (oss_level),
    .o_code_valid (code_valid),
    .o_code       (code)
  );

  // millisecond tick shared by cool-down and watchdog
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      tick_cnt_q <= 20'h00000;
      tick_q     <= 1'b0;
    end else if (i_clk_en) begin
      tick_q <= (tick_cnt_q == TICK_CYC[19:0] - 20'h00001);
      if (tick_cnt_q == TICK_CYC[19:0] - 20'h00001) begin
        tick_cnt_q <= 20'h00000;
      end else begin
        tick_cnt_q <= tick_cnt_q + 20'h00001;
      end
    end
  end

  // watchdog counts ticks since the last serial clock edge
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      wdog_cnt_q  <= 12'h000;
      wdog_fire_q <= 1'b0;
    end else if (i_clk_en) begin
      wdog_fire_q <= 1'b0;
      if (scl_edge) begin
        wdog_cnt_q <= 12'h000;
      end else if (tick_q && (wdog_cnt_q != WDOG_TICK[11:0])) begin
        wdog_cnt_q  <= wdog_cnt_q + 12'h001;
        wdog_fire_q <= (wdog_cnt_q == WDOG_TICK[11:0] - 12'h001);
      end
    end
  end

  // ports to be shut down by the fast shutdown input
  always @* begin
    kill_d = {NPORT{1'b0}};
    for (l = 0; l < NPORT; l = l + 1) begin
      if (!multi_mode) begin
        kill_d[l] = oss_level && prio_flags_q[l];
      end else begin
        kill_d[l] = code_valid && (code <= lvl_all[(l%4)*4 +: 3]);
      end
    end
  end

  // configuration registers
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      map_sel_q               <= `PSS_R_MAP_SEL;
      prio_flags_q            <= `PSS_R_BYTE;
      gen_mask_q              <= `PSS_R_BYTE;
      pwr_en_alt_q            <= `PSS_R_BYTE;
      lvl_lo_q                <= `PSS_R_BYTE;
      lvl_hi_q                <= `PSS_R_BYTE;
      on_tim_aux_q            <= `PSS_R_BYTE;
      wdog_dis_q              <= `PSS_R_WDOG_DIS;
      watchdog_expired_flag_q <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_soft_rst) begin
        // soft reset clears settings but keeps the port map and the watchdog register
        prio_flags_q <= `PSS_R_BYTE;
        gen_mask_q   <= `PSS_R_BYTE;
        pwr_en_alt_q <= `PSS_R_BYTE;
        lvl_lo_q     <= `PSS_R_BYTE;
        lvl_hi_q     <= `PSS_R_BYTE;
        on_tim_aux_q <= `PSS_R_BYTE;
      end else if (i_reg_wr) begin
        case (i_reg_addr)
          `PSS_A_PRIO_FLAGS: prio_flags_q <= i_reg_wdata;
          `PSS_A_GEN_MASK:   gen_mask_q   <= i_reg_wdata;
          `PSS_A_PWR_EN_ALT: pwr_en_alt_q <= i_reg_wdata;
          `PSS_A_LVL_LO:     lvl_lo_q     <= i_reg_wdata;
          `PSS_A_LVL_HI:     lvl_hi_q     <= i_reg_wdata;
          `PSS_A_ON_TIM_AUX: on_tim_aux_q <= i_reg_wdata;
          `PSS_A_WDOG:       wdog_dis_q   <= i_reg_wdata[`PSS_F_WDOG_DIS];
          `PSS_A_MAP_SEL: begin
            if ((&i_port_off_mode) && map_unique) begin
              map_sel_q <= i_reg_wdata;
            end
          end
          default: begin
          end
        endcase
      end
      // flag set wins over a written zero
      if (wdog_fire_q) begin
        watchdog_expired_flag_q <= 1'b1;
      end else if (i_reg_wr && (i_reg_addr == `PSS_A_WDOG) &&
                   !i_reg_wdata[`PSS_B_WDOG_FLAG]) begin
        watchdog_expired_flag_q <= 1'b0;
      end
    end
  end

  // per logical port power, cool-down and detection permission
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_port
      reg [10:0] cool_cnt_q;
      wire       on_req = (wr_std_on && i_reg_wdata[g]) ||
                          (wr_alt_on && i_reg_wdata[g] && on_tim_aux_q[g]);
      always @(posedge i_ref_clk) begin
        if (i_srst) begin
          power_q[g]     <= 1'b0;
          cooling_q[g]   <= 1'b0;
          det_allow_q[g] <= 1'b0;
          kill_q[g]      <= 1'b0;
          cool_cnt_q     <= 11'h000;
        end else if (i_clk_en) begin
          kill_q[g] <= kill_d[g];
          if (wr_soft_rst || (wdog_fire_q && wdog_enabled)) begin
            power_q[g]     <= 1'b0;
            cooling_q[g]   <= 1'b0;
            det_allow_q[g] <= 1'b0;
          end else if (i_port_fault[g]) begin
            power_q[g]     <= 1'b0;
            cooling_q[g]   <= 1'b1;
            det_allow_q[g] <= 1'b0;
            cool_cnt_q     <= 11'h000;
          end else if (i_port_disconnect[g] || i_port_off_cmd[g] || kill_q[g]) begin
            power_q[g]     <= 1'b0;
            det_allow_q[g] <= 1'b0;
          end else if (cooling_q[g]) begin
            if (tick_q) begin
              cool_cnt_q <= cool_cnt_q + 11'h001;
            end
            if (cool_cnt_q == COOL_TICK[10:0]) begin
              cooling_q[g]   <= 1'b0;
              det_allow_q[g] <= 1'b1;
            end
          end else begin
            if (i_detect_request[g]) begin
              det_allow_q[g] <= 1'b1;
            end
            if (on_req && i_det_valid[g] && !i_class_bad[g]) begin
              power_q[g] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // logical to physical routing within each group of four
  always @* begin
    phys_power_d = {NPORT{1'b0}};
    phys_curve_d = {NPORT{1'b0}};
    phys_det_d   = {NPORT{1'b0}};
    for (k = 0; k < NPORT; k = k + 1) begin
      phys_power_d[(k/4)*4 + map_sel_q[(k%4)*2 +: 2]] = power_q[k];
      phys_curve_d[(k/4)*4 + map_sel_q[(k%4)*2 +: 2]] =
        power_q[k] && i_power_good[k] && i_extended_power_curve_select[k];
      phys_det_d[(k/4)*4 + map_sel_q[(k%4)*2 +: 2]]   = det_allow_q[k];
    end
  end

  // read data selection
  always @* begin
    case (i_reg_addr)
      `PSS_A_PRIO_FLAGS: rdata_d = prio_flags_q;
      `PSS_A_GEN_MASK:   rdata_d = gen_mask_q;
      `PSS_A_PWR_EN_ALT: rdata_d = pwr_en_alt_q;
      `PSS_A_STD_ON:     rdata_d = power_q[7:0];
      `PSS_A_MAP_SEL:    rdata_d = map_sel_q;
      `PSS_A_LVL_LO:     rdata_d = lvl_lo_q;
      `PSS_A_LVL_HI:     rdata_d = lvl_hi_q;
      `PSS_A_ON_TIM_AUX: rdata_d = on_tim_aux_q;
      `PSS_A_WDOG:       rdata_d = {3'h0, wdog_dis_q, watchdog_expired_flag_q};
      default:           rdata_d = 8'h00;
    endcase
  end

  // registered outputs
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_reg_rdata       <= 8'h00;
      o_port_power_on   <= {NPORT{1'b0}};
      o_curve_2x        <= {NPORT{1'b0}};
      o_detect_enable   <= {NPORT{1'b0}};
      o_serial_if_reset <= 1'b0;
    end else if (i_clk_en) begin
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_d;
      end
      o_port_power_on   <= phys_power_d;
      o_curve_2x        <= phys_curve_d;
      o_detect_enable   <= phys_det_d;
      o_serial_if_reset <= wdog_fire_q && wdog_enabled;
    end
  end

endmodule
`default_nettype wire

// ### pss_props.sv
// concurrent checks on the port supervisor pins
`timescale 1ns/1ps
`default_nettype none

module pss_props #(
  parameter int TICK_CYC  = 10,
  parameter int WDOG_TICK = 5
) (
  // clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_srst,
  input wire logic       i_clk_en,
  // register strobe and serial clock
  input wire logic       i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_scl,
  // port status
  input wire logic [7:0] i_port_fault,
  input wire logic [7:0] i_det_valid,
  input wire logic [7:0] i_extended_power_curve_select,
  // port controls
  input wire logic [7:0] o_port_power_on,
  input wire logic [7:0] o_curve_2x,
  input wire logic [7:0] o_detect_enable,
  input wire logic       o_serial_if_reset
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  logic        wd_en_q;
  logic        scl_q;
  logic [31:0] quiet_q;
  // last written watchdog enable, cycles since the serial clock moved
  always_ff @(posedge i_ref_clk) begin
    scl_q <= i_scl;
    if (i_srst) begin
      wd_en_q <= 1'b0;
      quiet_q <= '0;
    end else begin
      if (i_reg_wr && i_clk_en && i_reg_addr == 8'h30)
        wd_en_q <= (i_reg_wdata[4:1] != 4'hb);
      quiet_q <= (i_scl != scl_q) ? '0 : quiet_q + 1;
    end
  end
  a_reset_outs_low: assert property (disable iff (1'b0) i_srst |=> o_port_power_on == 8'h00)
    else $error("ports on after reset");
  a_wdog_needs_en: assert property (o_serial_if_reset |-> wd_en_q)
    else $error("interface reset while watchdog off");
  a_wdog_quiet: assert property (o_serial_if_reset |-> quiet_q >= (WDOG_TICK - 1) * TICK_CYC)
    else $error("expiry despite serial clock activity");
  a_wdog_single: assert property (o_serial_if_reset |=> !o_serial_if_reset)
    else $error("interface reset too long");
  a_wdog_ports_off: assert property (o_serial_if_reset |-> ##1 o_port_power_on == 8'h00)
    else $error("ports on after expiry");
  a_on_needs_valid: assert property (
    (o_port_power_on & ~$past(o_port_power_on)) != 8'h00 |-> $past(i_reg_wr, 2) && $past(i_det_valid, 2) != 8'h00)
    else $error("port on without valid command");
  a_cool_blocks: assert property (i_port_fault != 8'h00 |-> ##3 o_detect_enable != 8'hff)
    else $error("detection allowed during cool-down");
  a_curve_sel: assert property ((i_extended_power_curve_select == 8'h00) [*3] |-> o_curve_2x == 8'h00)
    else $error("doubled curve without select");
  a_curve_unpowered: assert property ((o_port_power_on == 8'h00) [*2] |-> o_curve_2x == 8'h00)
    else $error("doubled curve on unpowered ports");
  c_wdog: cover property (o_serial_if_reset);
  c_curve: cover property (o_curve_2x == 8'hff);
  c_cool: cover property (i_port_fault != 8'h00 ##[1:100] o_detect_enable[1]);
endmodule

bind pss_port_supervisor pss_props #(.TICK_CYC(TICK_CYC), .WDOG_TICK(WDOG_TICK)) i_pss_props (
  .i_ref_clk, .i_srst, .i_clk_en, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .i_scl, .i_port_fault, .i_det_valid,
  .i_extended_power_curve_select, .o_port_power_on, .o_curve_2x, .o_detect_enable, .o_serial_if_reset);

`default_nettype wire

// ### pss_shutdown_rx.v
// fast shutdown input deglitch filter and three-bit code receiver
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.vh"

module pss_shutdown_rx #(
  parameter integer DGL_CYC = `PSS_DGL_NS / `PSS_CLK_NS,
  parameter integer BIT_CYC = `PSS_BIT_NS / `PSS_CLK_NS
) (
  // clock, reset, enable
  input  wire       i_ref_clk,
  input  wire       i_srst,
  input  wire       i_clk_en,
  // synchronised line and mode
  input  wire       i_line,
  input  wire       i_multi_mode,
  // filtered level and received code
  output reg        o_level,
  output reg        o_code_valid,
  output reg  [2:0] o_code
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_BITS = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  reg [15:0] dgl_q;
  reg [15:0] bit_q;
  reg [1:0]  cnt_q;
  reg [2:0]  st_q;

  // deglitch: level follows the line only after it held steady
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      dgl_q   <= 16'h0000;
      o_level <= 1'b0;
    end else if (i_clk_en) begin
      if (i_line == o_level) begin
        dgl_q <= 16'h0000;
      end else if (dgl_q >= DGL_CYC[15:0]) begin
        o_level <= i_line;
        dgl_q   <= 16'h0000;
      end else begin
        dgl_q <= dgl_q + 16'h0001;
      end
    end
  end

  // frame: start bit, then three code bits msb first, sampled mid-bit
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_q         <= ST_IDLE;
      bit_q        <= 16'h0000;
      cnt_q        <= 2'h0;
      o_code       <= 3'h0;
      o_code_valid <= 1'b0;
    end else if (i_clk_en) begin
      o_code_valid <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          bit_q <= 16'h0000;
          cnt_q <= 2'h0;
          if (i_multi_mode && o_level) begin
            st_q <= ST_BITS;
          end
        end
        ST_BITS: begin
          bit_q <= bit_q + 16'h0001;
          if (!i_multi_mode) begin
            st_q <= ST_IDLE;
          end else if (bit_q == BIT_CYC[15:0] + BIT_CYC[15:0] / 16'h0002) begin
            o_code <= {o_code[1:0], o_level};
            bit_q  <= BIT_CYC[15:0] / 16'h0002;
            cnt_q  <= cnt_q + 2'h1;
            if (cnt_q == 2'h2) begin
              o_code_valid <= 1'b1;
              st_q         <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (!o_level || !i_multi_mode) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the port supervisor
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int TICK = 10;
  logic       i_ref_clk, i_srst, i_clk_en, i_reg_wr, i_reg_rd;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  wire        i_fast_shutdown_input, i_scl;
  logic [7:0] i_port_fault, i_port_disconnect, i_port_off_cmd, i_port_off_mode, i_detect_request;
  logic [7:0] i_det_valid, i_class_bad, i_power_good, i_extended_power_curve_select;
  logic [7:0] o_port_power_on, o_curve_2x, o_detect_enable;
  logic       o_serial_if_reset;
  int         errors, checks;

  pss_port_supervisor #(.NPORT(8), .TICK_CYC(TICK), .COOL_TICK(3), .WDOG_TICK(5)) i_pss_port_supervisor (
    .i_ref_clk, .i_srst, .i_clk_en, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .i_fast_shutdown_input, .i_scl, .i_port_fault, .i_port_disconnect, .i_port_off_cmd, .i_port_off_mode,
    .i_detect_request, .i_det_valid, .i_class_bad, .i_power_good, .i_extended_power_curve_select,
    .o_port_power_on, .o_curve_2x, .o_detect_enable, .o_serial_if_reset);
  pss_host_model i_pss_host_model (.i_ref_clk, .o_line(i_fast_shutdown_input), .o_scl(i_scl));

  // 125 MHz clock
  always #4 i_ref_clk = ~i_ref_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 chk(o_reg_rdata, exp);
  endtask
  task automatic pchk(input logic [7:0] exp);
    repeat (3) @(posedge i_ref_clk);
    #1 chk(o_port_power_on, exp);
  endtask
  // one-cycle pulse on disconnect (0), detect request (1) or off command (2)
  task automatic port_pulse(input int which, input logic [7:0] v);
    @(posedge i_ref_clk);
    case (which)
      0: i_port_disconnect <= v;
      1: i_detect_request <= v;
      default: i_port_off_cmd <= v;
    endcase
    @(posedge i_ref_clk);
    {i_port_disconnect, i_detect_request, i_port_off_cmd} <= '0;
    repeat (3) @(posedge i_ref_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial begin
    int n;
    i_ref_clk = 1'b0;
    i_srst = 1'b1;
    i_clk_en = 1'b1;
    {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
    {i_port_fault, i_port_disconnect, i_port_off_cmd, i_port_off_mode, i_detect_request} = '0;
    {i_det_valid, i_class_bad, i_extended_power_curve_select} = '0;
    i_power_good = 8'hff;
    repeat (6) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rdchk(8'h26, 8'he4);
    rdchk(8'h30, 8'h16);
    rdchk(8'h1a, 8'h00);
    $display("test reset done");
    wr(8'h23, 8'hff);
    pchk(8'h00);
    i_det_valid <= 8'hfe;
    i_class_bad <= 8'h02;
    wr(8'h23, 8'h07);
    pchk(8'h04);
    wr(8'h1a, 8'h00);
    $display("test turn-on gating done");
    wr(8'h26, 8'h39);
    rdchk(8'h26, 8'he4);
    i_port_off_mode <= 8'hff;
    wr(8'h26, 8'h00);
    rdchk(8'h26, 8'he4);
    wr(8'h26, 8'h39);
    rdchk(8'h26, 8'h39);
    i_port_off_mode <= 8'h00;
    wr(8'h1a, 8'h00);
    rdchk(8'h26, 8'h39);
    {i_det_valid, i_class_bad, i_extended_power_curve_select} <= {8'hff, 8'h00, 8'hff};
    wr(8'h23, 8'h11);
    pchk(8'h22);
    wr(8'h40, 8'h02);
    wr(8'h19, 8'h06);
    pchk(8'h26);
    $display("test remap done");
    wr(8'h15, 8'h0f);
    wr(8'h23, 8'hff);
    pchk(8'hff);
    chk(o_curve_2x, 8'hff);
    i_power_good <= 8'hf0;
    repeat (2) @(posedge i_ref_clk);
    #1 chk(o_curve_2x, 8'hf0);
    i_power_good <= 8'hff;
    i_pss_host_model.hold(1'b1, 200);
    i_pss_host_model.hold(1'b0, 20);
    pchk(8'hff);
    i_pss_host_model.hold(1'b1, 400);
    pchk(8'hf0);
    i_pss_host_model.hold(1'b0, 25000);
    $display("test single-bit shutdown done");
    wr(8'h17, 8'h80);
    wr(8'h27, 8'h31);
    wr(8'h28, 8'h75);
    wr(8'h23, 8'hff);
    pchk(8'hff);
    i_pss_host_model.frame(3'h3);
    pchk(8'h22);
    $display("test three-bit shutdown done");
    @(posedge i_ref_clk);
    i_port_fault <= 8'h01;
    @(posedge i_ref_clk);
    i_port_fault <= 8'h00;
    repeat (15) @(posedge i_ref_clk);
    #1 chk({7'h00, o_detect_enable[1]}, 8'h00);
    repeat (45) @(posedge i_ref_clk);
    #1 chk({7'h00, o_detect_enable[1]}, 8'h01);
    pchk(8'h20);
    $display("test cool-down done");
    port_pulse(0, 8'h01);
    #1 chk({7'h00, o_detect_enable[1]}, 8'h00);
    port_pulse(1, 8'h01);
    #1 chk({7'h00, o_detect_enable[1]}, 8'h01);
    port_pulse(2, 8'h01);
    #1 chk({7'h00, o_detect_enable[1]}, 8'h00);
    $display("test restart on request done");
    i_clk_en <= 1'b0;
    wr(8'h15, 8'haa);
    i_clk_en <= 1'b1;
    rdchk(8'h15, 8'h0f);
    $display("test clock enable done");
    i_pss_host_model.run = 1'b0;
    repeat (100) @(posedge i_ref_clk);
    rdchk(8'h30, 8'h17);
    pchk(8'h20);
    wr(8'h30, 8'h16);
    rdchk(8'h30, 8'h16);
    wr(8'h30, 8'h00);
    i_pss_host_model.run = 1'b1;
    repeat (100) @(posedge i_ref_clk);
    pchk(8'h20);
    i_pss_host_model.run = 1'b0;
    for (n = 0; n < 200 && o_serial_if_reset !== 1'b1; n++) begin
      @(posedge i_ref_clk);
      #1;
    end
    if (n == 200) begin
      chk({7'h00, o_serial_if_reset}, 8'h01);
      end_sim();
    end
    pchk(8'h00);
    rdchk(8'h30, 8'h01);
    $display("test watchdog done");
    i_srst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rdchk(8'h26, 8'he4);
    rdchk(8'h30, 8'h16);
    $display("test hard reset done");
    end_sim();
  end
endmodule

`default_nettype wire
